// [dv/serial_node_model.sv]
// Purpose: remote serial node that sends frames to the core and captures its output
// Assumes: 64 system clocks per serial bit, line idles high
// Notes:   got_r holds the bits after the start bit, first bit at index 0
`timescale 1ns/1ps
`default_nettype none
module serial_node_model (
    // clock
    input  wire logic clock,
    // serial lines
    output var  logic line_out,
    input  wire logic line_in
);
    ////////////////////////////////////////
    logic [10:0] got_r;
    int          frames;

    // line idles high so the receiver never starts early
    initial line_out = 1'b1;

    // one frame: start, 7/8 data bits, optional parity, one stop; flip spoils parity
    task automatic send(input logic [7:0] x, input logic l8, input logic msb,
                        input logic [1:0] p, input logic flip);
        logic [10:0] fr;
        logic [7:0]  pm;
        int          n;
        n = l8 ? 8 : 7;
        pm = l8 ? x : {1'b0, x[6:0]};
        fr = '1;
        for (int k = 0; k < n; k++) fr[k] = msb ? x[n-1-k] : x[k];
        if (p != 2'h0) fr[n] = flip ^ ((p == 2'h1) ? 1'b0 : ^{p == 2'h2, pm});
        @(negedge clock) line_out = 1'b0;
        repeat (64) @(negedge clock);
        for (int k = 0; k <= n + (p != 2'h0); k++) begin
            line_out = fr[k];
            repeat (64) @(negedge clock);
        end
    endtask : send

    // capture each outgoing frame mid-bit
    initial forever begin
        @(negedge line_in);
        repeat (32) @(posedge clock);
        for (int k = 0; k < 11; k++) begin
            repeat (64) @(posedge clock);
            got_r[k] = line_in;
        end
        frames++;
    end
endmodule : serial_node_model
`default_nettype wire

// [dv/uart_core_buffers_and_mode_tb.sv]
// Purpose: self-checking bench for the serial core
// Assumes: remote node model on the serial pins
// Notes:   expected frames and bytes are built here
`timescale 1ns/1ps
`default_nettype none
module uart_core_buffers_and_mode_tb;
    import uart_core_pkg::*;
    ////////////////////////////////////////
    logic       clock, rst, msb_sel, rx_line, tx_line, rc_irq, re_irq, tc_irq;
    logic [7:0] rdata, v, m, d;
    cpu_req_t   req;
    int         fails, num_checks, n_rc, n_re, n_tc, c, f, t, b;

    // device and remote node
    uart_core_buffers_and_mode uut (.clock(clock), .rst(rst), .ce(1'b1), .cpu_req(req),
        .cpu_rdata(rdata), .msb_first_sel(msb_sel), .serial_in_pin(rx_line),
        .serial_out_pin(tx_line), .receive_complete_irq(rc_irq),
        .receive_error_irq(re_irq), .transmit_complete_irq(tc_irq));
    serial_node_model node (.clock(clock), .line_out(rx_line), .line_in(tx_line));

    // clock, watchdog and interrupt pulse counters
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #400000;
        fails++;
        stop_test();
    end
    always @(posedge clock) begin
        n_rc += (rc_irq === 1'b1);
        n_re += (re_irq === 1'b1);
        n_tc += (tc_irq === 1'b1);
    end

    // verdict and end of run
    task automatic stop_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic check(input string s, input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask : check

    // a bounded wait that ran out ends the run
    task automatic expire(input int cnt, input int lim);
        if (cnt >= lim) begin
            fails++;
            stop_test();
        end
    endtask : expire

    // cpu accesses, one-cycle strobes
    task automatic wr(input logic [15:0] a, input logic [7:0] x, input logic [7:0] k);
        @(negedge clock) req = {1'b1, 1'b0, a, x, k};
        @(negedge clock) req = '0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] x);
        @(negedge clock) req = {1'b0, 1'b1, a, 16'h0000};
        @(negedge clock) req = '0;
        @(negedge clock) x = rdata;
    endtask : rd

    // expected frame after the start bit in line order, idle high beyond it
    function automatic logic [10:0] frm(input logic [7:0] x, input logic l8,
                                        input logic [1:0] p, input logic msb);
        logic [10:0] r;
        logic [7:0]  y;
        int          n;
        n = l8 ? 8 : 7;
        for (int k = 0; k < 8; k++) y[k] = (msb && k < n) ? x[n-1-k] : x[k];
        r = l8 ? {3'h7, y} : {4'hf, y[6:0]};
        if (p != 2'h0)
            r[l8 ? 8 : 7] = (p == 2'h1) ? 1'b0 : ^{p == 2'h2, r[7:0] & (l8 ? 8'hff : 8'h7f)};
        return r;
    endfunction : frm

    // format with enables off, enable receive, take one frame
    task automatic rx_case(input logic [4:0] fm, input logic [7:0] x, input logic msb,
                           input logic flip, input logic [7:0] exp_b, exp_e);
        int rc0, re0;
        wr(MODE_ADDR, 8'h00, 8'h60);
        wr(MODE_ADDR, {3'b100, fm}, 8'hff);
        repeat (12) @(negedge clock);
        wr(MODE_ADDR, {3'b101, fm}, 8'hff);
        repeat (8) @(negedge clock);
        msb_sel = msb;
        rc0 = n_rc;
        re0 = n_re;
        node.send(x, fm[2], msb, fm[4:3], flip);
        repeat (8) @(negedge clock);
        check("rx done irq", 11'(n_rc - rc0), 11'(exp_e == 0 || fm[0]));
        check("rx error irq", 11'(n_re - re0), 11'(exp_e != 0 && !fm[0]));
        rd(ERR_ADDR, v); check("rx status", v, exp_e);
        rd(RXB_ADDR, v);
        if (exp_e == 8'h00) check("rx byte", v, exp_b);
    endtask : rx_case

    // main sequence
    initial begin
        req = '0;
        msb_sel = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock) rst = 1'b0;
        rd(MODE_ADDR, v); check("mode reset", v, MODE_RESET);
        wr(RXB_ADDR, 8'h00, 8'hff);
        rd(RXB_ADDR, v); check("rx buffer", v, BUF_RESET);
        rd(TXB_ADDR, v); check("tx buffer", v, BUF_RESET);
        wr(MODE_ADDR, 8'h80, 8'h80);
        rd(MODE_ADDR, v); check("mode bit write", v, 8'h81);
        for (int i = 0; i < 4; i++) begin
            m = {3'b100, 2'(i), ~i[0], i[0] ^ i[1], 1'b0};
            d = 8'hc6 ^ 8'(i);
            msb_sel = i[1];
            wr(MODE_ADDR, 8'h00, 8'h40);
            wr(MODE_ADDR, m, 8'hff);
            repeat (12) @(negedge clock);
            wr(MODE_ADDR, m | 8'h40, 8'hff);
            repeat (8) @(negedge clock);
            f = node.frames;
            t = n_tc;
            wr(TXB_ADDR, d, 8'hff);
            for (c = 0; c < 300 && tx_line === 1'b1; c++) @(negedge clock);
            expire(c, 300);
            for (c = 0; c < 1200 && n_tc == t; c++) @(negedge clock);
            expire(c, 1200);
            b = 2 + (i[0] ? 7 : 8) + (i != 0) + (i[0] ^ i[1]);
            check("tx length", 11'((c + 8) / 64), 11'(b));
            for (c = 0; c < 1200 && node.frames == f; c++) @(negedge clock);
            expire(c, 1200);
            check("tx bits", node.got_r, frm(d, ~i[0], 2'(i), i[1]));
        end
        rx_case(5'b11100, 8'hc3, 1'b0, 1'b0, 8'hc3, 8'h00);
        rx_case(5'b10000, 8'h4b, 1'b0, 1'b0, 8'h4b, 8'h00);
        rx_case(5'b00000, 8'h4b, 1'b1, 1'b0, 8'h96, 8'h00);
        rx_case(5'b01110, 8'h3c, 1'b0, 1'b1, 8'h3c, 8'h00);
        rx_case(5'b11100, 8'h3c, 1'b0, 1'b1, 8'h00, 8'h04);
        rx_case(5'b11101, 8'h3c, 1'b0, 1'b1, 8'h00, 8'h04);
        msb_sel = 1'b0;
        node.send(8'h11, 1'b1, 1'b0, 2'h3, 1'b0);
        node.send(8'h22, 1'b1, 1'b0, 2'h3, 1'b0);
        repeat (8) @(negedge clock);
        rd(ERR_ADDR, v); check("overrun flag", v, 8'h01);
        rd(RXB_ADDR, v); check("kept byte", v, 8'h11);
        node.send(8'h33, 1'b1, 1'b0, 2'h3, 1'b0);
        wr(MODE_ADDR, 8'hdd, 8'hff);
        repeat (12) @(negedge clock);
        wr(TXB_ADDR, 8'h00, 8'hff);
        repeat (200) @(negedge clock);
        check("pin in frame", 11'(tx_line), 11'(0));
        wr(MODE_ADDR, 8'h00, 8'hff);
        repeat (8) @(negedge clock);
        check("pin after off", 11'(tx_line), 11'(1));
        rd(RXB_ADDR, v); check("rx buffer off", v, BUF_RESET);
        rd(TXSTAT_ADDR, v); check("tx status off", v, 8'h00);
        stop_test();
    end
endmodule : uart_core_buffers_and_mode_tb
`default_nettype wire

// [hdl/uart_core_buffers_and_mode.sv]
// Purpose: serial transceiver core with buffers, shifters and mode register
// Assumes: cpu access strobes last one clock; pins synchronous to clock
// Notes:   read data appears one clock after the read strobe
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module uart_core_buffers_and_mode
    import uart_core_pkg::*;
(
    // clock and reset
    input  wire logic     clock,
    input  wire logic     rst,
    input  wire logic     ce,
    // cpu access
    input  wire cpu_req_t cpu_req,
    output var  logic [7:0] cpu_rdata,
    // direction select from auxiliary control
    input  wire logic     msb_first_sel,
    // serial pins
    input  wire logic     serial_in_pin,
    output var  logic     serial_out_pin,
    // interrupts
    output var  logic     receive_complete_irq,
    output var  logic     receive_error_irq,
    output var  logic     transmit_complete_irq
);

    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} frame_t;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [2:0] last_idx(input logic len8);
        last_idx = len8 ? IDX_LAST8 : IDX_LAST7;
    endfunction : last_idx

    function automatic logic par_calc(input logic [7:0] d, input logic len8,
                                      input parity_t p);
        logic ones;
        ones = ^(len8 ? d : {1'b0, d[6:0]});
        case (p)
            PAR_ODD:  par_calc = ~ones;
            PAR_EVEN: par_calc = ones;
            default:  par_calc = 1'b0;
        endcase
    endfunction : par_calc

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] mode_r;
    logic [7:0] txb_r, rxb_r, txs_r, rxs_r, cpu_rdata_r;
    logic [3:0] div_r, tx_cnt_r, rx_cnt_r;
    logic [2:0] tx_idx_r, rx_idx_r;
    logic       tx_on_r, rx_on_r, txbf_r, tx_stop2_r, rx_par_r;
    logic       pe_r, fe_r, ove_r, rxb_full_r;
    logic       tx_pin_r, rc_irq_r, re_irq_r, tc_irq_r;
    frame_t     tx_st_r, rx_st_r;

    ////////////////////////////////////////////////////////////////////////////////
    // decode
    wire parity_t par_mode   = parity_t'(mode_r[PAR_HI_BIT:PAR_LO_BIT]);
    wire logic    power_on   = mode_r[POWER_BIT];
    wire logic    len8       = mode_r[CLEN_BIT];
    wire logic    tick       = ce && (div_r == BASE_DIV_LAST);
    wire logic    rx_in      = power_on ? serial_in_pin : 1'b1;
    wire logic    wr_mode    = cpu_req.wr && (cpu_req.addr == MODE_ADDR);
    wire logic    wr_txb     = cpu_req.wr && (cpu_req.addr == TXB_ADDR) && power_on;
    wire logic    rd_rxb     = cpu_req.rd && (cpu_req.addr == RXB_ADDR);
    wire logic    rd_err     = cpu_req.rd && (cpu_req.addr == ERR_ADDR);
    wire logic    tx_bit_end = tick && (tx_cnt_r == BIT_LAST);
    wire logic    rx_bit_end = tick && (rx_cnt_r == BIT_LAST);
    wire logic    tx_frame_end = tx_on_r && (tx_st_r == S_STOP) && tx_bit_end
                                 && (!mode_r[STOP_BIT] || tx_stop2_r);
    wire logic    tx_load_now = tick && tx_on_r && txbf_r
                                && ((tx_st_r == S_IDLE) || tx_frame_end);
    wire logic    rx_sample  = power_on && rx_on_r && (rx_st_r == S_STOP) && rx_bit_end;
    wire logic [7:0] rx_next = msb_first_sel ? {rxs_r[6:0], rx_in} : {rx_in, rxs_r[7:1]};
    wire logic [7:0] rx_data = len8 ? rxs_r
                             : (msb_first_sel ? {rxs_r[6:0], 1'b0}
                                              : {1'b0, rxs_r[7:1]});
    // pad bit of rx_data is zero, so parity is taken over the whole byte
    wire logic    rx_pe      = rx_sample && (par_mode == PAR_ODD || par_mode == PAR_EVEN)
                               && (rx_par_r != par_calc(rx_data, 1'b1, par_mode));
    wire logic    rx_fe      = rx_sample && !rx_in;
    wire logic    rx_ove     = rx_sample && rxb_full_r;
    wire logic    rx_err     = rx_pe || rx_fe || rx_ove;

    ////////////////////////////////////////////////////////////////////////////////
    // base clock divider
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            div_r <= 4'h0;
        else if (ce)
            div_r <= (div_r == BASE_DIV_LAST) ? 4'h0 : div_r + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode register, bit or byte writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            mode_r <= MODE_RESET;
        else if (ce && wr_mode)
            mode_r <= (mode_r & ~cpu_req.wmask) | (cpu_req.wdata & cpu_req.wmask);
    end

    // enables taken on the base clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_on_r <= 1'b0;
            rx_on_r <= 1'b0;
        end else if (ce && !power_on) begin
            tx_on_r <= 1'b0;
            rx_on_r <= 1'b0;
        end else if (tick) begin
            tx_on_r <= mode_r[TXE_BIT];
            rx_on_r <= mode_r[RXE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit buffer and full flag
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            txb_r  <= BUF_RESET;
            txbf_r <= 1'b0;
        end else if (ce) begin
            if (wr_txb)
                txb_r <= cpu_req.wdata;
            if (!power_on || !tx_on_r)
                txbf_r <= 1'b0;
            else if (wr_txb)
                txbf_r <= 1'b1;
            else if (tx_load_now)
                txbf_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmitter frame sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_st_r <= S_IDLE;
            tx_cnt_r <= 4'h0;
            tx_idx_r <= 3'h0;
            tx_stop2_r <= 1'b0;
            txs_r <= BUF_RESET;
            tx_pin_r <= 1'b1;
            tc_irq_r <= 1'b0;
        end else if (ce) begin
            tc_irq_r <= 1'b0;
            if (!power_on || !tx_on_r) begin
                tx_st_r <= S_IDLE;
                tx_cnt_r <= 4'h0;
                tx_pin_r <= 1'b1;
            end else if (tick) begin
                tx_cnt_r <= tx_cnt_r + 4'h1;
                if (tx_load_now) begin
                    txs_r <= txb_r;
                    tc_irq_r <= tx_frame_end;
                    tx_st_r <= S_START;
                    tx_cnt_r <= 4'h0;
                    tx_pin_r <= 1'b0;
                end else if (tx_bit_end) begin
                    case (tx_st_r)
                        S_START: begin
                            tx_st_r <= S_DATA;
                            tx_idx_r <= 3'h0;
                            tx_pin_r <= msb_first_sel ? txs_r[last_idx(len8)] : txs_r[0];
                        end
                        S_DATA: begin
                            if (tx_idx_r == last_idx(len8)) begin
                                tx_st_r <= (par_mode == PAR_NONE) ? S_STOP : S_PAR;
                                tx_pin_r <= (par_mode == PAR_NONE) ? 1'b1
                                          : par_calc(txs_r, len8, par_mode);
                                tx_stop2_r <= 1'b0;
                            end else begin
                                tx_idx_r <= tx_idx_r + 3'h1;
                                tx_pin_r <= msb_first_sel
                                    ? txs_r[last_idx(len8) - tx_idx_r - 3'h1]
                                    : txs_r[tx_idx_r + 3'h1];
                            end
                        end
                        S_PAR: begin
                            tx_st_r <= S_STOP;
                            tx_pin_r <= 1'b1;
                            tx_stop2_r <= 1'b0;
                        end
                        S_STOP: begin
                            tx_pin_r <= 1'b1;
                            tx_stop2_r <= 1'b1;
                            if (tx_frame_end) begin
                                tc_irq_r <= 1'b1;
                                tx_st_r <= S_IDLE;
                            end
                        end
                        default: tx_st_r <= S_IDLE;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receiver frame sequencer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_st_r <= S_IDLE;
            rx_cnt_r <= 4'h0;
            rx_idx_r <= 3'h0;
            rxs_r <= BUF_RESET;
            rx_par_r <= 1'b0;
        end else if (ce) begin
            if (!power_on || !rx_on_r) begin
                rx_st_r <= S_IDLE;
                rx_cnt_r <= 4'h0;
            end else if (tick) begin
                rx_cnt_r <= rx_cnt_r + 4'h1;
                case (rx_st_r)
                    S_IDLE: begin
                        rx_cnt_r <= 4'h0;
                        if (!rx_in)
                            rx_st_r <= S_START;
                    end
                    S_START: if (rx_cnt_r == HALF_LAST) begin
                        rx_cnt_r <= 4'h0;
                        rx_idx_r <= 3'h0;
                        rx_st_r <= rx_in ? S_IDLE : S_DATA;
                    end
                    S_DATA: if (rx_bit_end) begin
                        rxs_r <= rx_next;
                        rx_idx_r <= rx_idx_r + 3'h1;
                        if (rx_idx_r == last_idx(len8))
                            rx_st_r <= (par_mode == PAR_NONE) ? S_STOP : S_PAR;
                    end
                    S_PAR: if (rx_bit_end) begin
                        rx_par_r <= rx_in;
                        rx_st_r <= S_STOP;
                    end
                    S_STOP: if (rx_bit_end)
                        rx_st_r <= S_IDLE;
                    default: rx_st_r <= S_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive buffer, error flags and receive interrupts
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxb_r <= BUF_RESET;
            rxb_full_r <= 1'b0;
            {pe_r, fe_r, ove_r} <= 3'h0;
            rc_irq_r <= 1'b0;
            re_irq_r <= 1'b0;
        end else if (ce) begin
            rc_irq_r <= 1'b0;
            re_irq_r <= 1'b0;
            if (!power_on) begin
                rxb_r <= BUF_RESET;
                rxb_full_r <= 1'b0;
                {pe_r, fe_r, ove_r} <= 3'h0;
            end else begin
                if (rx_sample && !rx_ove) begin
                    rxb_r <= rx_data;
                    rxb_full_r <= 1'b1;
                end else if (rd_rxb)
                    rxb_full_r <= 1'b0;
                if (!rx_on_r && !mode_r[RXE_BIT])
                    {pe_r, fe_r, ove_r} <= 3'h0;
                else if (rx_sample)
                    {pe_r, fe_r, ove_r} <= {pe_r | rx_pe, fe_r | rx_fe, ove_r | rx_ove};
                else if (rd_err)
                    {pe_r, fe_r, ove_r} <= 3'h0;
                if (rx_sample) begin
                    re_irq_r <= rx_err && !mode_r[ROUTE_BIT];
                    rc_irq_r <= !rx_err || mode_r[ROUTE_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            cpu_rdata_r <= ZERO_BYTE;
        else if (ce && cpu_req.rd) begin
            case (cpu_req.addr)
                MODE_ADDR:   cpu_rdata_r <= mode_r;
                RXB_ADDR:    cpu_rdata_r <= rxb_r;
                TXB_ADDR:    cpu_rdata_r <= txb_r;
                ERR_ADDR:    cpu_rdata_r <= {5'h00, pe_r, fe_r, ove_r};
                TXSTAT_ADDR: cpu_rdata_r <= {6'h00, txbf_r, tx_st_r != S_IDLE};
                default:     cpu_rdata_r <= ZERO_BYTE;
            endcase
        end
    end

    assign cpu_rdata             = cpu_rdata_r;
    assign serial_out_pin        = tx_pin_r;
    assign receive_complete_irq  = rc_irq_r;
    assign receive_error_irq     = re_irq_r;
    assign transmit_complete_irq = tc_irq_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    rx7_lsb_top_a: assert property (rc_irq_r && !len8 && !msb_first_sel
        && !$past(msb_first_sel) && !$past(rx_ove) |-> !rxb_r[7])
        else $error("7-bit lsb data top bit not zero");
    rx7_msb_low_a: assert property (rc_irq_r && !len8 && msb_first_sel
        && $past(msb_first_sel) && !$past(rx_ove) |-> !rxb_r[0])
        else $error("7-bit msb data low bit not zero");
    overrun_hold_a: assert property (rx_ove && power_on |=> $stable(rxb_r))
        else $error("overrun changed receive buffer");
    rxb_write_a: assert property (wr_mode == 1'b0 && cpu_req.wr
        && cpu_req.addr == RXB_ADDR && !rx_sample && power_on |=> $stable(rxb_r))
        else $error("receive buffer took a write");
    tx_start_a: assert property (wr_txb && ce && tx_on_r && tx_st_r == S_IDLE
        && mode_r[POWER_BIT] ##1 power_on && tx_on_r [*8] |-> tx_st_r == S_START)
        else $error("transmit buffer write did not start a frame");
    pin_tick_a: assert property ($changed(tx_pin_r) && power_on
        && $past(power_on) && $past(tx_on_r) |-> $past(tick))
        else $error("serial output moved off the base clock");
    power_off_a: assert property (!power_on && ce |=> tx_pin_r && !txbf_r
        && rxb_r == BUF_RESET && !pe_r && !fe_r && !ove_r)
        else $error("power off left state alive");
    zero_par_a: assert property (par_mode == PAR_ZERO |-> !rx_pe)
        else $error("parity checked in zero parity mode");
    route_err_a: assert property (rx_sample && rx_err && ce |=>
        (re_irq_r != rc_irq_r) && (re_irq_r == !$past(mode_r[ROUTE_BIT])))
        else $error("error interrupt routed wrongly");

endmodule : uart_core_buffers_and_mode

`default_nettype wire

// [hdl/uart_core_pkg.sv]
// Purpose: shared constants and types for the serial transceiver core
// Assumes: 8-bit cpu data, 16-bit cpu addresses
// Notes:   base clock is a divided tick of the system clock
package uart_core_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [15:0] MODE_ADDR   = 16'hff50;  // serial_mode_control
    localparam logic [15:0] RXB_ADDR    = 16'hff51;  // receive_holding_buffer
    localparam logic [15:0] TXB_ADDR    = 16'hff52;  // transmit_holding_buffer
    localparam logic [15:0] ERR_ADDR    = 16'hff53;  // receive_error_status
    localparam logic [15:0] TXSTAT_ADDR = 16'hff55;  // transmit_status

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] MODE_RESET = 8'h01;
    localparam logic [7:0] BUF_RESET  = 8'hff;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // mode register fields
    localparam int POWER_BIT  = 7;
    localparam int TXE_BIT    = 6;
    localparam int RXE_BIT    = 5;
    localparam int PAR_HI_BIT = 4;
    localparam int PAR_LO_BIT = 3;
    localparam int CLEN_BIT   = 2;
    localparam int STOP_BIT   = 1;
    localparam int ROUTE_BIT  = 0;

    // status fields
    localparam int PE_BIT   = 2;
    localparam int FE_BIT   = 1;
    localparam int OVE_BIT  = 0;
    localparam int TXBF_BIT = 1;
    localparam int TXSF_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // timing: system clocks per base clock, base clocks per serial bit
    localparam logic [3:0] BASE_DIV_LAST = 4'h3;   // divide by 4
    localparam logic [3:0] BIT_LAST      = 4'hf;   // 16 base clocks per bit
    localparam logic [3:0] HALF_LAST     = 4'h7;   // mid-bit of start bit
    localparam logic [2:0] IDX_LAST8     = 3'h7;
    localparam logic [2:0] IDX_LAST7     = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // parity modes
    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_ZERO = 2'h1,
        PAR_ODD  = 2'h2,
        PAR_EVEN = 2'h3
    } parity_t;

    // one cpu access; wmask selects bits for bit-wise writes
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  wmask;
    } cpu_req_t;

endpackage : uart_core_pkg
